// ---- hw/nvm_regs_pkg.sv ----
// constants for the nonvolatile controller register tail
// assumes an apb slave with 32-bit data, one byte register per aligned word
package nvm_regs_pkg;
    // printed byte offsets are register indices; byte address is four times index
    localparam logic [3:0] INTERRUPT_ENABLE_REG_IDX    = 4'h3;
    localparam logic [3:0] FLAGS_IDX      = 4'h4;
    localparam logic [3:0] DATA_LOW_IDX   = 4'h6;
    localparam logic [3:0] DATA_HIGH_IDX  = 4'h7;
    localparam logic [3:0] ADDR_LOW_IDX   = 4'h8;
    localparam logic [3:0] ADDR_MID_IDX   = 4'h9;
    localparam logic [3:0] ADDR_EXT_IDX   = 4'hA;
    localparam logic [3:0] STATUS_IDX     = 4'h2;
    localparam logic [3:0] IRQ_MASK_IDX   = 4'hC;
    localparam logic [3:0] IRQ_STAT_IDX   = 4'hD;
    // field positions
    localparam int READY_BIT      = 0;
    localparam int EEPROM_BUSY_STATUS_BIT     = 1;
    localparam int EV_READY_BIT   = 0;
    localparam int EV_READ_BIT    = 1;
    localparam int EV_ACCESS_BIT  = 2;
    // reset values
    localparam logic [7:0]  BYTE_RESET  = 8'h00;
    localparam logic [15:0] DATA_RESET  = 16'h0000;
    localparam logic [23:0] ADDR_RESET  = 24'h000000;
    localparam logic [2:0]  EV_RESET    = 3'h0;
    // address width actually used per memory
    localparam int EEPROM_ABITS = 9;
    localparam int FLASH_ABITS  = 16;
    // memory select of a datapath access
    typedef enum logic [1:0] {MEM_FLASH, MEM_EEPROM, MEM_CTRL} mem_sel_type;
endpackage : nvm_regs_pkg

// ---- hw/nvm_event_status.sv ----
// sticky event status with write-one-to-clear and mask, one level interrupt out
// assumes events are one-cycle or level pulses in the pclk domain
`timescale 1ns/10ps
`default_nettype none
module nvm_event_status (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // events and software access
    input  wire logic [2:0] event_set,
    input  wire logic [2:0] clear_ones,
    input  wire logic       mask_we,
    input  wire logic [2:0] mask_wdata,
    // state out
    output var  logic [2:0] status_q,
    output var  logic [2:0] mask_q,
    output var  logic       irq_q
);
    import nvm_regs_pkg::*;
    logic [2:0] status_r, status_nxt;
    logic [2:0] mask_r, mask_nxt;
    logic       irq_r, irq_nxt;

    // set wins over a clear in the same cycle
    always_comb begin
        status_nxt = (status_r & ~clear_ones) | event_set;
        mask_nxt   = mask_we ? mask_wdata : mask_r;
        irq_nxt    = |(status_nxt & mask_nxt);
    end

    // state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= EV_RESET;
            mask_r   <= EV_RESET;
            irq_r    <= 1'b0;
        end else begin
            status_r <= status_nxt;
            mask_r   <= mask_nxt;
            irq_r    <= irq_nxt;
        end
    end

    assign status_q = status_r;
    assign mask_q   = mask_r;
    assign irq_q    = irq_r;
endmodule : nvm_event_status
`default_nettype wire

// ---- hw/nvm_ready_regs.sv ----
// register tail of the nonvolatile controller: ready interrupt, data and address
// assumes apb master in pclk domain; busy and datapath strobes synchronous to pclk
//
// Functional notes
// R1 - interrupt control bit 0 enables the eeprom ready interrupt
// R2 - ready interrupt is a level, high while flag and enable both set
// R3 - software enables the interrupt only after issuing a write or erase
// R4 - handler must clear the enable bit or the interrupt keeps firing
// R5 - ready flag at bit 0 of offset 4 set every cycle eeprom idle
// R6 - writing one clears the ready flag; it sets again when not busy
// R7 - writing zero or unused flag bits changes nothing
// R8 - sixteen-bit data register at 6, low byte then high byte
// R9 - every read result loads the data register
// R10 - eeprom reads fill only the low data byte
// R11 - 24-bit address register at 8, low, mid, extended bytes
// R12 - every memory access updates the address register
// R13 - only address bits needed by the memory take effect
// R14 - flag, data and address registers reset to zero
// R15 - status bit 1 shows eeprom busy, complement of ready source
`timescale 1ns/10ps
`default_nettype none
module nvm_ready_regs (
    // clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output var  logic [31:0]               prdata,
    output var  logic                      pready,
    output var  logic                      pslverr,
    // controller status and datapath
    input  wire logic                      eeprom_busy,
    input  wire logic                      rd_valid,
    input  wire nvm_regs_pkg::mem_sel_type rd_mem,
    input  wire logic [15:0]               rd_data,
    input  wire logic                      acc_valid,
    input  wire nvm_regs_pkg::mem_sel_type acc_mem,
    input  wire logic [23:0]               acc_addr,
    // outputs to the controller and cpu
    output var  logic [23:0]               access_address,
    output var  logic [15:0]               read_data,
    output var  logic                      eeprom_ready_irq,
    output var  logic                      irq
);
    import nvm_regs_pkg::*;

    logic        enable_r, enable_nxt;
    logic        flag_r, flag_nxt;
    logic [15:0] data_r, data_nxt;
    logic [23:0] addr_r, addr_nxt;
    logic        rdy_irq_r, rdy_irq_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt;
    logic        pslverr_r, pslverr_nxt;
    logic        busy_r;
    logic        wr_en, rd_en, mapped, lane0;
    logic [3:0]  idx;
    logic [7:0]  wbyte;
    logic [2:0]  ev_status, ev_mask, ev_set, ev_clr;
    logic        ev_irq;

    // clip an address to the bits a memory actually decodes
    function automatic logic [23:0] clip_addr(input mem_sel_type m, input logic [23:0] a);
        logic [23:0] r;
        r = a;
        unique case (m)
            MEM_EEPROM: r = {{(24-EEPROM_ABITS){1'b0}}, a[EEPROM_ABITS-1:0]};
            MEM_FLASH:  r = {{(24-FLASH_ABITS){1'b0}}, a[FLASH_ABITS-1:0]};
            MEM_CTRL:   r = a;
            default:    r = a;
        endcase
        return r;
    endfunction : clip_addr

    // register index decode
    function automatic logic is_mapped(input logic [3:0] i);
        return (i == INTERRUPT_ENABLE_REG_IDX) || (i == FLAGS_IDX) || (i == DATA_LOW_IDX) ||
               (i == DATA_HIGH_IDX) || (i == ADDR_LOW_IDX) || (i == ADDR_MID_IDX) ||
               (i == ADDR_EXT_IDX) || (i == STATUS_IDX) || (i == IRQ_MASK_IDX) ||
               (i == IRQ_STAT_IDX);
    endfunction : is_mapped

    // apb decode: one access cycle, answered next edge
    always_comb begin
        idx    = paddr[5:2];
        mapped = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00) && is_mapped(idx);
        wr_en  = psel && penable && !pready_r && pwrite && mapped;
        rd_en  = psel && penable && !pready_r && !pwrite;
        lane0  = pstrb[0];
        wbyte  = pwdata[7:0];
    end

    // event sources: eeprom idle level, read loaded, access logged
    always_comb begin
        ev_set = 3'b000;
        ev_set[EV_READY_BIT]  = !eeprom_busy;
        ev_set[EV_READ_BIT]   = rd_valid;
        ev_set[EV_ACCESS_BIT] = acc_valid;
        ev_clr = (wr_en && lane0 && idx == IRQ_STAT_IDX) ? wbyte[2:0] : 3'b000;
    end

    nvm_event_status u_events (
        .pclk       (pclk),
        .presetn    (presetn),
        .event_set  (ev_set),
        .clear_ones (ev_clr),
        .mask_we    (wr_en && lane0 && idx == IRQ_MASK_IDX),
        .mask_wdata (wbyte[2:0]),
        .status_q   (ev_status),
        .mask_q     (ev_mask),
        .irq_q      (ev_irq)
    );

    // register next values
    always_comb begin
        enable_nxt = enable_r;
        flag_nxt   = flag_r;
        data_nxt   = data_r;
        addr_nxt   = addr_r;
        if (wr_en && lane0) begin
            unique case (idx)
                INTERRUPT_ENABLE_REG_IDX:   enable_nxt = wbyte[READY_BIT]; // R1 R4
                FLAGS_IDX:     if (wbyte[READY_BIT]) flag_nxt = 1'b0; // R6 R7
                DATA_LOW_IDX:  data_nxt[7:0] = wbyte; // R8
                DATA_HIGH_IDX: data_nxt[15:8] = wbyte; // R8
                ADDR_LOW_IDX:  addr_nxt[7:0] = wbyte; // R11
                ADDR_MID_IDX:  addr_nxt[15:8] = wbyte; // R11
                ADDR_EXT_IDX:  addr_nxt[23:16] = wbyte; // R11
                default:       ;
            endcase
        end
        // hardware set after the clear, so the set wins
        if (!eeprom_busy) begin
            flag_nxt = 1'b1; // R5 R6
        end
        if (rd_valid) begin
            if (rd_mem == MEM_EEPROM) begin
                data_nxt = {8'h00, rd_data[7:0]}; // R10
            end else begin
                data_nxt = rd_data; // R9
            end
        end
        if (acc_valid) begin
            addr_nxt = clip_addr(acc_mem, acc_addr); // R12 R13
        end
        rdy_irq_nxt = flag_nxt && enable_nxt; // R2
    end

    // read mux and bus answer
    always_comb begin
        prdata_nxt  = 32'h00000000;
        pready_nxt  = psel && penable && !pready_r;
        pslverr_nxt = psel && penable && !pready_r && !mapped;
        if (rd_en && mapped) begin
            unique case (idx)
                INTERRUPT_ENABLE_REG_IDX:   prdata_nxt[READY_BIT] = enable_r;
                FLAGS_IDX:     prdata_nxt[READY_BIT] = flag_r;
                STATUS_IDX:    prdata_nxt[EEPROM_BUSY_STATUS_BIT] = busy_r; // R15
                DATA_LOW_IDX:  prdata_nxt[7:0] = data_r[7:0];
                DATA_HIGH_IDX: prdata_nxt[7:0] = data_r[15:8];
                ADDR_LOW_IDX:  prdata_nxt[7:0] = addr_r[7:0];
                ADDR_MID_IDX:  prdata_nxt[7:0] = addr_r[15:8];
                ADDR_EXT_IDX:  prdata_nxt[7:0] = addr_r[23:16];
                IRQ_MASK_IDX:  prdata_nxt[2:0] = ev_mask;
                IRQ_STAT_IDX:  prdata_nxt[2:0] = ev_status;
                default:       ;
            endcase
        end
    end

    // registers; everything clears to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_r  <= 1'b0;
            flag_r    <= 1'b0; // R14
            data_r    <= DATA_RESET; // R14
            addr_r    <= ADDR_RESET; // R14
            rdy_irq_r <= 1'b0;
            busy_r    <= 1'b0;
            prdata_r  <= 32'h00000000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            enable_r  <= enable_nxt;
            flag_r    <= flag_nxt;
            data_r    <= data_nxt;
            addr_r    <= addr_nxt;
            rdy_irq_r <= rdy_irq_nxt;
            busy_r    <= eeprom_busy;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // outputs straight from flip-flops
    assign prdata           = prdata_r;
    assign pready           = pready_r;
    assign pslverr          = pslverr_r;
    assign read_data        = data_r;
    assign access_address   = addr_r;
    assign eeprom_ready_irq = rdy_irq_r;
    assign irq              = ev_irq;
endmodule : nvm_ready_regs
`default_nettype wire

// ---- tb/nvm_ready_regs_props.sv ----
// assertions on the register tail ports
// assumes a single pclk domain, bound from tb_top
`timescale 1ns/10ps
`default_nettype none
module nvm_ready_regs_props
    import nvm_regs_pkg::*;
(
    // clock, reset, apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // datapath and outputs
    input wire logic        eeprom_busy,
    input wire logic        rd_valid,
    input wire mem_sel_type rd_mem,
    input wire logic [15:0] rd_data,
    input wire logic        acc_valid,
    input wire mem_sel_type acc_mem,
    input wire logic [23:0] acc_addr,
    input wire logic [23:0] access_address,
    input wire logic [15:0] read_data,
    input wire logic        eeprom_ready_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // an access phase that the slave has not yet answered
    sequence s_take;
        psel && penable && !pready;
    endsequence
    a_ans_wait: assert property (s_take |=> pready) else $error("no answer after access");
    a_ans_pulse: assert property (pready |=> !pready) else $error("pready held");
    a_err_ready: assert property (pslverr |-> pready) else $error("error without pready");
    a_rd_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
    a_data_eeprom: assert property (rd_valid && rd_mem == MEM_EEPROM |=>
        read_data == {8'h00, $past(rd_data[7:0])}) else $error("eeprom data load");
    a_data_flash: assert property (rd_valid && rd_mem == MEM_FLASH |=>
        read_data == $past(rd_data)) else $error("flash data load");
    a_addr_eeprom: assert property (acc_valid && acc_mem == MEM_EEPROM |=>
        access_address == {15'h0, $past(acc_addr[8:0])}) else $error("eeprom address clip");
    a_addr_flash: assert property (acc_valid && acc_mem == MEM_FLASH |=>
        access_address == {8'h00, $past(acc_addr[15:0])}) else $error("flash address clip");
    a_addr_hold: assert property (!acc_valid && !(psel && penable && pwrite) |=>
        $stable(access_address)) else $error("address changed without access");
    a_ready_irq_stays: assert property (eeprom_ready_irq && !eeprom_busy && !(psel && penable && pwrite)
        |=> eeprom_ready_irq) else $error("ready interrupt dropped while idle");
endmodule : nvm_ready_regs_props
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the register tail
// assumes the package and checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import nvm_regs_pkg::*;
    // stimulus and observed signals
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, eeprom_busy = 1'b1, rd_valid = 1'b0, acc_valid = 1'b0;
    mem_sel_type rd_mem = MEM_FLASH, acc_mem = MEM_FLASH;
    logic [15:0] rd_data = 16'h0, read_data;
    logic [23:0] acc_addr = 24'h0, access_address;
    logic        eeprom_ready_irq, irq;
    int          miscompares = 0, checked = 0;
    // ordinary cases: write, address, data or expected read, expected error
    typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic e;} row_type;
    row_type rows [16] = '{'{0, 8'h10, 8'h00, 0}, '{0, 8'h18, 8'h00, 0}, '{0, 8'h1C, 8'h00, 0},
        '{0, 8'h20, 8'h00, 0}, '{0, 8'h28, 8'h00, 0}, '{1, 8'h18, 8'hA5, 0}, '{0, 8'h18, 8'hA5, 0},
        '{1, 8'h1C, 8'h3C, 0}, '{0, 8'h1C, 8'h3C, 0}, '{1, 8'h24, 8'h5A, 0}, '{0, 8'h24, 8'h5A, 0},
        '{1, 8'h28, 8'hC3, 0}, '{0, 8'h28, 8'hC3, 0}, '{0, 8'h0C, 8'h00, 0}, '{1, 8'h40, 8'hFF, 1},
        '{0, 8'h40, 8'h00, 1}};
    always #20 pclk = ~pclk;
    // device under test
    nvm_ready_regs nvm_ready_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .eeprom_busy(eeprom_busy), .rd_valid(rd_valid), .rd_mem(rd_mem), .rd_data(rd_data),
        .acc_valid(acc_valid), .acc_mem(acc_mem), .acc_addr(acc_addr), .access_address(access_address),
        .read_data(read_data), .eeprom_ready_irq(eeprom_ready_irq), .irq(irq));
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= {24'h0, d};
            @(posedge pclk);
            penable <= 1'b1;
            // only the watchdog ends a wait that never gets an answer
            do begin
                @(posedge pclk);
            end while (pready !== 1'b1);
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb
    // one datapath pulse, read load or access log
    task automatic dp(input logic r, input mem_sel_type m, input logic [23:0] v);
        begin
            @(posedge pclk);
            rd_valid <= r;
            acc_valid <= !r;
            rd_mem <= m;
            acc_mem <= m;
            rd_data <= v[15:0];
            acc_addr <= v;
            @(posedge pclk);
            rd_valid <= 1'b0;
            acc_valid <= 1'b0;
            @(negedge pclk);
        end
    endtask : dp
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            checked++;
            if (got !== exp) begin
                miscompares++;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask : chk
    task automatic report_and_stop;
        if (miscompares == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    // watchdog against a hung handshake
    initial begin
        repeat (3000) @(posedge pclk);
        miscompares++;
        report_and_stop();
    end
    // main sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(rd, {24'h0, rows[i].d});
            chk({31'h0, er}, {31'h0, rows[i].e});
        end
        // ready flag and its interrupt around a programming phase
        apb(1'b1, 8'h0C, 8'h01);
        apb(1'b0, 8'h08, 8'h00);
        chk(rd, 32'h2);
        eeprom_busy <= 1'b0;
        apb(1'b1, 8'h10, 8'hFE);
        apb(1'b0, 8'h10, 8'h00);
        chk(rd, 32'h1);
        chk({31'h0, eeprom_ready_irq}, 32'h1);
        eeprom_busy <= 1'b1;
        apb(1'b1, 8'h10, 8'h01);
        apb(1'b0, 8'h10, 8'h00);
        chk(rd, 32'h0);
        chk({31'h0, eeprom_ready_irq}, 32'h0);
        eeprom_busy <= 1'b0;
        apb(1'b0, 8'h10, 8'h00);
        chk(rd, 32'h1);
        apb(1'b1, 8'h0C, 8'h00);
        apb(1'b0, 8'h0C, 8'h00);
        chk({31'h0, eeprom_ready_irq}, 32'h0);
        // datapath loads and address clipping per memory
        dp(1'b1, MEM_FLASH, 24'h00BEEF);
        chk({16'h0, read_data}, 32'hBEEF);
        dp(1'b1, MEM_EEPROM, 24'h00BEEF);
        chk({16'h0, read_data}, 32'h00EF);
        dp(1'b0, MEM_EEPROM, 24'hFFFFFF);
        chk({8'h0, access_address}, 32'h1FF);
        dp(1'b0, MEM_FLASH, 24'hFFFFFF);
        chk({8'h0, access_address}, 32'hFFFF);
        dp(1'b0, MEM_CTRL, 24'hFFFFFF);
        chk({8'h0, access_address}, 32'hFFFFFF);
        // event status, mask and write-one-to-clear
        apb(1'b1, 8'h30, 8'h06);
        apb(1'b0, 8'h34, 8'h00);
        chk(rd & 32'h6, 32'h6);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, 8'h30, 8'h00);
        apb(1'b0, 8'h30, 8'h00);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 8'h30, 8'h06);
        apb(1'b1, 8'h34, 8'h06);
        apb(1'b0, 8'h34, 8'h00);
        chk(rd & 32'h6, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // mid-run reset clears data, address and flag that hold non-zero values
        eeprom_busy <= 1'b1;
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        chk({16'h0, read_data}, 32'h0);
        chk({8'h0, access_address}, 32'h0);
        presetn <= 1'b1;
        apb(1'b0, 8'h10, 8'h00);
        chk(rd, 32'h0);
        report_and_stop();
    end
endmodule : tb_top
bind nvm_ready_regs nvm_ready_regs_props nvm_ready_regs_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eeprom_busy(eeprom_busy), .rd_valid(rd_valid), .rd_mem(rd_mem), .rd_data(rd_data), .acc_valid(acc_valid),
    .acc_mem(acc_mem), .acc_addr(acc_addr), .access_address(access_address), .read_data(read_data),
    .eeprom_ready_irq(eeprom_ready_irq));
`default_nettype wire
